// ==== core/sdo_map.vh ====
// constants of the setup override block: map, setup layout, timing
`ifndef SDO_MAP_VH
`define SDO_MAP_VH
`define SDO_CLK_HZ      50000000
`define SDO_DEF_BAUD    300
`define SDO_DEB_MS      10
`define SDO_OFS_CTRL    8'h00
`define SDO_OFS_STAT    8'h04
`define SDO_OFS_DIR     8'h08
`define SDO_OFS_OUT     8'h0c
`define SDO_OFS_CHAN    8'h10
`define SDO_OFS_PINS    8'h14
`define SDO_OFS_SETUP   8'h18
`define SDO_CTRL_CONT   0
`define SDO_CTRL_BIN    1
`define SDO_CHAN_DIR    3
`define SDO_CHAN_VAL    4
`define SDO_NV_RST      32'h00020031
`define SDO_SU_ADDR     7:0
`define SDO_SU_BAUD     15:12
`define SDO_SU_PAR      11:10
`define SDO_SU_DIR      31:24
`define SDO_DEF_CODE    4'h0
`define SDO_DEF_PAR     2'h0
`define SDO_CH_SOF      8'h24
`define SDO_CH_HASH     8'h23
`define SDO_CH_CR       8'h0d
`define SDO_CH_NUL      8'h00
`define SDO_CH_OK       8'h2a
`define SDO_CH_ERR      8'h3f
`define SDO_CH_R        8'h52
`define SDO_CH_S        8'h53
`define SDO_CH_U        8'h55
`endif

// ==== core/sdo_fifo.v ====
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sdo_fifo #(
	parameter W  = 8,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire         clk,
	input  wire         sys_rst,
	input  wire         ce,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	localparam [AW:0] FULL = D[AW:0];

	reg  [W-1:0] mem [0:D-1];
	reg  [AW:0]  wr_q;
	reg  [AW:0]  rd_q;
	wire         push;
	wire         pop;

	assign in_ready  = (wr_q - rd_q) != FULL;
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem[rd_q[AW-1:0]];
	assign push      = ce & in_valid & in_ready;
	assign pop       = ce & out_valid & out_ready;

	always @(posedge clk) begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== core/sdo_uart.v ====
// serial receiver and transmitter, 8 data bits, optional parity, 1 stop
`timescale 1ns/1ps
`default_nettype none
module sdo_uart (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        ce,
	input  wire [17:0] div,
	input  wire [1:0]  par,
	input  wire        rx_en,
	input  wire        rxd,
	output reg         rx_valid,
	output reg  [7:0]  rx_data,
	input  wire        tx_valid,
	output wire        tx_ready,
	input  wire [7:0]  tx_data,
	output reg         txd
);
	// par: 0 none, 1 odd, 2 even, 3 mark
	function par_bit;
		input [1:0] p;
		input [7:0] d;
		begin
			case (p)
			2'h1:    par_bit = ~^d;
			2'h2:    par_bit = ^d;
			default: par_bit = 1'b1;
			endcase
		end
	endfunction

	reg  [17:0] rx_cnt_q;
	reg  [3:0]  rx_bit_q;
	reg         rx_busy_q;
	reg  [8:0]  rx_sh_q;
	reg  [17:0] tx_cnt_q;
	reg  [3:0]  tx_left_q;
	reg  [10:0] tx_sh_q;
	wire        has_par = par != 2'h0;
	wire [3:0]  rx_last = has_par ? 4'ha : 4'h9;
	wire [7:0]  rx_byte = has_par ? rx_sh_q[7:0] : rx_sh_q[8:1];
	wire        par_ok  = ~has_par | (rx_sh_q[8] == par_bit(par, rx_byte));

	// -------------------------------------------------------------
	// receiver: samples mid-bit after a half-period start check
	// -------------------------------------------------------------
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_cnt_q  <= 18'h0;
			rx_bit_q  <= 4'h0;
			rx_busy_q <= 1'b0;
			rx_sh_q   <= 9'h0;
			rx_valid  <= 1'b0;
			rx_data   <= 8'h0;
		end else if (ce) begin
			rx_valid <= 1'b0;
			if (!rx_busy_q) begin
				if (rx_en && !rxd) begin
					rx_busy_q <= 1'b1;
					rx_cnt_q  <= {1'b0, div[17:1]};
					rx_bit_q  <= 4'h0;
				end
			end else if (rx_cnt_q != 18'h0) begin
				rx_cnt_q <= rx_cnt_q - 18'h1;
			end else begin
				rx_cnt_q <= div - 18'h1;
				rx_bit_q <= rx_bit_q + 4'h1;
				if (rx_bit_q == 4'h0) begin
					if (rxd)
						rx_busy_q <= 1'b0;
				end else if (rx_bit_q == rx_last) begin
					// framing or parity errors drop the byte
					rx_busy_q <= 1'b0;
					rx_valid  <= rxd & par_ok;
					rx_data   <= rx_byte;
				end else begin
					rx_sh_q <= {rxd, rx_sh_q[8:1]};
				end
			end
		end
	end

	// -------------------------------------------------------------
	// transmitter
	// -------------------------------------------------------------
	assign tx_ready = (tx_left_q == 4'h0) && (tx_cnt_q == 18'h0);

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_cnt_q  <= 18'h0;
			tx_left_q <= 4'h0;
			tx_sh_q   <= 11'h7ff;
			txd       <= 1'b1;
		end else if (ce) begin
			if (tx_cnt_q != 18'h0) begin
				tx_cnt_q <= tx_cnt_q - 18'h1;
			end else if (tx_left_q != 4'h0) begin
				txd       <= tx_sh_q[0];
				tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
				tx_left_q <= tx_left_q - 4'h1;
				tx_cnt_q  <= div - 18'h1;
			end else begin
				txd <= 1'b1;
				if (tx_valid) begin
					tx_sh_q   <= {1'b1, has_par ?
						par_bit(par, tx_data) : 1'b1, tx_data, 1'b0};
					tx_left_q <= has_par ? 4'hb : 4'ha;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== core/sdo_top.v ====
// setup override top: strap, setup store, command parser, channels
`timescale 1ns/1ps
`default_nettype none
`include "sdo_map.vh"
// Summary of operation
// - strap low forces 300 baud, 8 data, 1 stop, no parity
// - strap low accepts any address except NUL, CR, dollar, hash
// - strap never alters the stored setup
// - every command works while the strap is low
// - setup writes under strap change storage, not active format
// - strap release causes program reset and stored format
// - error reply sends own address right after question mark
// - read setup returns stored setup including address code
// - stored per-channel direction applied at power-up and reset
// - channels set singly or all at once, input or output
// - continuous mode only allowed under the ascii protocol
// - all setup fields writable over the serial port
// - factory setup: address 1, 300 baud, plain, delay two
module sdo_top #(
	parameter BASE_DIV = `SDO_CLK_HZ / `SDO_DEF_BAUD,
	parameter DEB_CYC  = `SDO_CLK_HZ / 1000 * `SDO_DEB_MS
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        ce,
	input  wire        default_n,
	input  wire        rxd,
	output wire        txd,
	input  wire [7:0]  addr,
	input  wire [31:0] wr_data,
	input  wire        wr_en,
	input  wire        rd_en,
	output wire [31:0] rd_data,
	input  wire [7:0]  chan_in,
	output wire [7:0]  chan_out,
	output wire [7:0]  chan_oe,
	output wire        default_mode,
	output wire        cont_mode
);
	localparam [17:0] BDIV    = BASE_DIV[17:0];
	localparam [19:0] DEB_N   = DEB_CYC[19:0];
	localparam [19:0] DEB_END = DEB_N - 20'h1;
	localparam        ST_BOOT = 1'b0;
	localparam        ST_RUN  = 1'b1;
	localparam [2:0]  P_IDLE  = 3'h0;
	localparam [2:0]  P_ADDR  = 3'h1;
	localparam [2:0]  P_C1    = 3'h2;
	localparam [2:0]  P_C2    = 3'h3;
	localparam [2:0]  P_ARG   = 3'h4;
	localparam [2:0]  P_RESP  = 3'h5;
	localparam [1:0]  K_OK    = 2'h0;
	localparam [1:0]  K_SET   = 2'h1;
	localparam [1:0]  K_ERR   = 2'h2;

	function [7:0] hex_ch;
		input [3:0] n;
		begin
			if (n < 4'ha)
				hex_ch = 8'h30 + {4'h0, n};
			else
				hex_ch = 8'h37 + {4'h0, n};
		end
	endfunction

	function [4:0] hex_val;
		input [7:0] c;
		begin
			if (c >= 8'h30 && c <= 8'h39)
				hex_val = {1'b1, c[3:0]};
			else if (c >= 8'h41 && c <= 8'h46)
				hex_val = {1'b1, c[3:0] + 4'h9};
			else
				hex_val = 5'h00;
		end
	endfunction

	reg         sync1_q;
	reg         sync2_q;
	reg         strap_q;
	reg         rel_q;
	reg  [19:0] deb_q;
	reg         state_q;
	reg  [31:0] nv_q;
	reg  [3:0]  run_code_q;
	reg  [1:0]  run_par_q;
	reg  [7:0]  dir_q;
	reg  [7:0]  out_q;
	reg  [1:0]  ctrl_q;
	reg         dflt_q;
	reg         cont_q;
	reg  [31:0] rd_q;
	reg  [2:0]  p_q;
	reg  [15:0] cmd_q;
	reg  [31:0] arg_q;
	reg  [3:0]  narg_q;
	reg         bad_q;
	reg  [1:0]  kind_q;
	reg  [3:0]  ridx_q;
	reg  [7:0]  resp_byte;
	reg  [31:0] nv_sh;
	wire        dflt;
	wire [3:0]  act_code;
	wire [1:0]  act_par;
	wire [17:0] div;
	wire        rx_valid;
	wire [7:0]  rx_data;
	wire [4:0]  hv;
	wire        addr_ok;
	wire        push_ready;
	wire        tx_valid;
	wire        tx_ready;
	wire [7:0]  tx_data;
	wire [3:0]  last_idx;

	// -------------------------------------------------------------
	// strap pin: two-stage sync, then a stability counter
	// -------------------------------------------------------------
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			strap_q <= 1'b1;
			rel_q   <= 1'b0;
			deb_q   <= 20'h0;
		end else if (ce) begin
			sync1_q <= default_n;
			sync2_q <= sync1_q;
			rel_q   <= 1'b0;
			if (sync2_q == strap_q) begin
				deb_q <= 20'h0;
			end else if (deb_q == DEB_END) begin
				strap_q <= sync2_q;
				rel_q   <= sync2_q;
				deb_q   <= 20'h0;
			end else begin
				deb_q <= deb_q + 20'h1;
			end
		end
	end

	assign dflt = ~strap_q;
	// forced format only while the strap is low; storage is untouched
	assign act_code = dflt ? `SDO_DEF_CODE : run_code_q;
	assign act_par  = dflt ? `SDO_DEF_PAR : run_par_q;
	assign div      = BDIV >> act_code;

	// -------------------------------------------------------------
	// program reset, channel control and register writes
	// -------------------------------------------------------------
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q    <= ST_BOOT;
			run_code_q <= `SDO_DEF_CODE;
			run_par_q  <= `SDO_DEF_PAR;
			dir_q      <= 8'h00;
			out_q      <= 8'h00;
			ctrl_q     <= 2'h0;
			dflt_q     <= 1'b0;
			cont_q     <= 1'b0;
		end else if (ce) begin
			dflt_q <= dflt;
			cont_q <= ctrl_q[`SDO_CTRL_CONT] &
				~ctrl_q[`SDO_CTRL_BIN];
			if (rel_q) begin
				state_q <= ST_BOOT;
			end else if (state_q == ST_BOOT) begin
				// setup is in place before the receiver opens
				run_code_q <= nv_q[`SDO_SU_BAUD];
				run_par_q  <= nv_q[`SDO_SU_PAR];
				dir_q      <= nv_q[`SDO_SU_DIR];
				out_q      <= 8'h00;
				ctrl_q     <= 2'h0;
				state_q    <= ST_RUN;
			end else if (wr_en) begin
				case (addr)
				`SDO_OFS_CTRL: ctrl_q <= wr_data[1:0];
				`SDO_OFS_DIR:  dir_q <= wr_data[7:0];
				`SDO_OFS_OUT:  out_q <= wr_data[7:0];
				`SDO_OFS_CHAN: begin
					if (wr_data[`SDO_CHAN_DIR])
						dir_q[wr_data[2:0]] <=
							wr_data[`SDO_CHAN_VAL];
					else
						out_q[wr_data[2:0]] <=
							wr_data[`SDO_CHAN_VAL];
				end
				default: ;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// register reads: data in the cycle after the strobe only
	// -------------------------------------------------------------
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_q <= 32'h0;
		end else if (ce) begin
			rd_q <= 32'h0;
			if (rd_en) begin
				case (addr)
				`SDO_OFS_CTRL:  rd_q <= {30'h0, ctrl_q};
				`SDO_OFS_STAT:  rd_q <= {23'h0, state_q, cont_q,
					dflt, act_par, act_code};
				`SDO_OFS_DIR:   rd_q <= {24'h0, dir_q};
				`SDO_OFS_OUT:   rd_q <= {24'h0, out_q};
				`SDO_OFS_PINS:  rd_q <= {24'h0, chan_in};
				`SDO_OFS_SETUP: rd_q <= nv_q;
				default:        rd_q <= 32'h0;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// command parser: start, address, two command letters, hex, CR
	// -------------------------------------------------------------
	assign hv      = hex_val(rx_data);
	assign addr_ok = dflt ?
		(rx_data != `SDO_CH_NUL && rx_data != `SDO_CH_CR &&
		 rx_data != `SDO_CH_SOF && rx_data != `SDO_CH_HASH) :
		(rx_data == nv_q[`SDO_SU_ADDR]);
	assign last_idx = (kind_q == K_OK) ? 4'h1 :
		(kind_q == K_SET) ? 4'h9 : 4'h2;

	always @* begin
		nv_sh     = nv_q >> {4'h8 - ridx_q, 2'h0};
		resp_byte = `SDO_CH_CR;
		case (kind_q)
		K_OK: begin
			if (ridx_q == 4'h0)
				resp_byte = `SDO_CH_OK;
		end
		K_SET: begin
			if (ridx_q == 4'h0)
				resp_byte = `SDO_CH_OK;
			else if (ridx_q != 4'h9)
				resp_byte = hex_ch(nv_sh[3:0]);
		end
		default: begin
			if (ridx_q == 4'h0)
				resp_byte = `SDO_CH_ERR;
			else if (ridx_q == 4'h1)
				resp_byte = nv_q[`SDO_SU_ADDR];
		end
		endcase
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			p_q    <= P_IDLE;
			cmd_q  <= 16'h0;
			arg_q  <= 32'h0;
			narg_q <= 4'h0;
			bad_q  <= 1'b0;
			kind_q <= K_OK;
			ridx_q <= 4'h0;
			nv_q   <= `SDO_NV_RST;
		end else if (ce) begin
			if (state_q == ST_BOOT) begin
				p_q <= P_IDLE;
			end else begin
				case (p_q)
				P_IDLE: begin
					if (rx_valid && (rx_data == `SDO_CH_SOF ||
					    rx_data == `SDO_CH_HASH))
						p_q <= P_ADDR;
				end
				P_ADDR: begin
					// an address character is always expected
					if (rx_valid)
						p_q <= addr_ok ? P_C1 : P_IDLE;
				end
				P_C1: begin
					if (rx_valid) begin
						cmd_q[15:8] <= rx_data;
						p_q         <= P_C2;
					end
				end
				P_C2: begin
					if (rx_valid) begin
						cmd_q[7:0] <= rx_data;
						arg_q      <= 32'h0;
						narg_q     <= 4'h0;
						bad_q      <= 1'b0;
						p_q        <= P_ARG;
					end
				end
				P_ARG: begin
					if (rx_valid && rx_data == `SDO_CH_CR) begin
						ridx_q <= 4'h0;
						p_q    <= P_RESP;
						// no command is gated by the strap
						if (!bad_q && narg_q == 4'h0 && cmd_q ==
						    {`SDO_CH_R, `SDO_CH_S}) begin
							kind_q <= K_SET;
						end else if (!bad_q && narg_q == 4'h8 &&
						    cmd_q == {`SDO_CH_S, `SDO_CH_U}) begin
							kind_q <= K_OK;
							nv_q   <= arg_q;
						end else begin
							kind_q <= K_ERR;
						end
					end else if (rx_valid) begin
						if (hv[4] && narg_q != 4'h8) begin
							arg_q  <= {arg_q[27:0], hv[3:0]};
							narg_q <= narg_q + 4'h1;
						end else begin
							bad_q <= 1'b1;
						end
					end
				end
				P_RESP: begin
					// input is ignored while the reply is queued, not while it is sent
					if (push_ready) begin
						ridx_q <= ridx_q + 4'h1;
						if (ridx_q == last_idx)
							p_q <= P_IDLE;
					end
				end
				default: p_q <= P_IDLE;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// reply buffer and serial port
	// -------------------------------------------------------------
	sdo_fifo #(
		.W  (8),
		.D  (16),
		.AW (4)
	) u_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.ce        (ce),
		.in_valid  (p_q == P_RESP),
		.in_ready  (push_ready),
		.in_data   (resp_byte),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);

	sdo_uart u_uart (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.div      (div),
		.par      (act_par),
		.rx_en    (state_q == ST_RUN),
		.rxd      (rxd),
		.rx_valid (rx_valid),
		.rx_data  (rx_data),
		.tx_valid (tx_valid),
		.tx_ready (tx_ready),
		.tx_data  (tx_data),
		.txd      (txd)
	);

	assign rd_data      = rd_q;
	assign chan_out     = out_q;
	assign chan_oe      = dir_q;
	assign default_mode = dflt_q;
	assign cont_mode    = cont_q;
endmodule
`default_nettype wire

// ==== bench/sdo_top_chk.sv ====
// assertion checker bound to the setup override top
`timescale 1ns/1ps
`default_nettype none
module sdo_top_chk #(
	parameter BASE_DIV = 16,
	parameter DEB_CYC  = 4
) (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        ce,
	input wire logic        default_n,
	input wire logic        rxd,
	input wire logic        txd,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wr_data,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [31:0] rd_data,
	input wire logic [7:0]  chan_in,
	input wire logic [7:0]  chan_out,
	input wire logic [7:0]  chan_oe,
	input wire logic        default_mode,
	input wire logic        cont_mode
);
	// -------------------------------
	// strap run lengths, in cycles
	// -------------------------------
	int lo_q;
	int hi_q;
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lo_q <= 0;
			hi_q <= 0;
		end else begin
			lo_q <= default_n ? 0 : lo_q + 1;
			hi_q <= default_n ? hi_q + 1 : 0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// a frozen clock enable holds the read register, so gate on it
	rd_idle_a: assert property ($past(ce) && !$past(rd_en)
		|-> rd_data == 32'h0) else $error("read data not zero");
	rd_hole_a: assert property (ce && rd_en
		&& (addr == 8'h10 || addr == 8'h1c)
		|=> rd_data == 32'h0) else $error("write-only or hole read");
	deb_enter_a: assert property ($rose(default_mode) |-> lo_q >= DEB_CYC)
		else $error("default mode entered early");
	deb_leave_a: assert property ($fell(default_mode) |-> hi_q >= DEB_CYC)
		else $error("default mode left early");
	dir_all_a: assert property (ce && wr_en && addr == 8'h08
		|=> chan_oe == $past(wr_data[7:0])) else $error("dir write");
	out_all_a: assert property (ce && wr_en && addr == 8'h0c
		|=> chan_out == $past(wr_data[7:0])) else $error("out write");
	out_one_a: assert property (ce && wr_en && addr == 8'h10
		&& !wr_data[3]
		|=> chan_out[$past(wr_data[2:0])] == $past(wr_data[4]))
		else $error("single output write");
	cont_ascii_a: assert property (ce && wr_en && addr == 8'h00 ##1 ce
		|=> cont_mode == ($past(wr_data[0], 2) & !$past(wr_data[1], 2)))
		else $error("continuous mode gating");
	stat_def_a: assert property (ce && rd_en && addr == 8'h04
		&& default_mode
		|=> rd_data[6:0] == 7'h40) else $error("default format");
	cover property ($rose(default_mode));
	cover property ($fell(default_mode));
	cover property ($rose(cont_mode));
endmodule
bind sdo_top sdo_top_chk #(.BASE_DIV(BASE_DIV), .DEB_CYC(DEB_CYC)) i_chk (
	.clk(clk), .sys_rst(sys_rst), .ce(ce), .default_n(default_n),
	.rxd(rxd), .txd(txd), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
	.rd_en(rd_en), .rd_data(rd_data), .chan_in(chan_in),
	.chan_out(chan_out), .chan_oe(chan_oe),
	.default_mode(default_mode), .cont_mode(cont_mode)
);
`default_nettype wire

// ==== bench/sdo_host.sv ====
// host terminal model on the serial link
`timescale 1ns/1ps
`default_nettype none
module sdo_host (
	input  wire logic       clk,
	input  wire logic       txd,
	output var  logic       rxd,
	output var  logic       got,
	output var  logic [7:0] got_byte
);
	// bench retimes these after a format change
	int         div = 16;
	logic [1:0] par = 2'h0;
	// 1 odd, 2 even, otherwise a fixed one, which doubles as the stop bit when par is 0
	function automatic logic par_of(input logic [7:0] b);
		return (par == 2'h1) ? ~^b : (par == 2'h2) ? ^b : 1'b1;
	endfunction
	initial begin
		rxd = 1'b1;
		got = 1'b0;
		got_byte = 8'h00;
	end
	// start, 8 data lsb first, parity if set, stop; idle line stays high
	task automatic send(input logic [7:0] b);
		logic [10:0] f;
		f = {1'b1, par_of(b), b, 1'b0};
		for (int i = 0; i < ((par != 2'h0) ? 11 : 10); i++) begin
			rxd <= f[i];
			repeat (div) @(posedge clk);
		end
	endtask
	always begin
		@(negedge txd);
		repeat (div / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(posedge clk);
			got_byte[i] = txd;
		end
		if (par != 2'h0) begin
			repeat (div) @(posedge clk);
			// a wrong parity bit spoils the byte so the bench flags it
			if (txd !== par_of(got_byte))
				got_byte = ~got_byte;
		end
		repeat (div) @(posedge clk);
		got <= 1'b1;
		@(posedge clk);
		got <= 1'b0;
	end
endmodule
`default_nettype wire

// ==== bench/test_serial_default_setup_override.sv ====
// self-checking bench for the setup override block
`timescale 1ns/1ps
`default_nettype none
`include "sdo_map.vh"
`define SDO_CHECK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_serial_default_setup_override;
	logic        clk, sys_rst, ce, default_n, rxd, txd, wr_en, rd_en, got;
	logic [7:0]  addr, chan_in, chan_out, chan_oe, got_byte, e8;
	logic [31:0] wr_data, rd_data, e32;
	logic        default_mode, cont_mode, rd_q;
	logic [31:0] exp_rd[$];
	logic [7:0]  exp_rx[$];
	logic [31:0] lfsr = 32'd89191;
	int          bad_count = 0;
	int          compares = 0;
	int          cycles = 0;
	sdo_top #(.BASE_DIV(16), .DEB_CYC(4)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .ce(ce), .default_n(default_n),
		.rxd(rxd), .txd(txd), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.chan_in(chan_in), .chan_out(chan_out), .chan_oe(chan_oe),
		.default_mode(default_mode), .cont_mode(cont_mode)
	);
	sdo_host i_host (.clk(clk), .txd(txd), .rxd(rxd), .got(got),
		.got_byte(got_byte));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ------------------------------
	// monitors: oldest note vs result
	// ------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			tally_and_finish();
		end
		if (rd_q) begin
			e32 = exp_rd.pop_front();
			`SDO_CHECK("rd_data", e32, rd_data)
		end
		if (got) begin
			e8 = exp_rx.pop_front();
			`SDO_CHECK("reply", e8, got_byte)
		end
		rd_q <= rd_en;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// empty reply: a frame the block must ignore
	task automatic cmd(input string s, input string r);
		foreach (r[i]) exp_rx.push_back(r[i]);
		foreach (s[i]) i_host.send(s[i]);
		for (int k = 0; k < 3000 && exp_rx.size() > 0; k++) @(posedge clk);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		default_n = 1'b1;
		addr = 8'h00;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		chan_in = 8'h00;
		rd_q = 1'b0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(`SDO_OFS_STAT, 32'h00000100);
		rd(`SDO_OFS_SETUP, `SDO_NV_RST);
		wr(`SDO_OFS_DIR, 32'h000000a5);
		wr(`SDO_OFS_CHAN, 32'h0000000f);
		wr(`SDO_OFS_OUT, 32'h000000ff);
		wr(`SDO_OFS_CHAN, 32'h00000000);
		settle(1);
		`SDO_CHECK("oe", 8'h25, chan_oe)
		`SDO_CHECK("out", 8'hfe, chan_out)
		// a write while the clock enable is low must be lost
		@(posedge clk);
		ce <= 1'b0;
		wr(`SDO_OFS_DIR, 32'h000000ff);
		ce <= 1'b1;
		rd(`SDO_OFS_DIR, 32'h00000025);
		rd(`SDO_OFS_CHAN, 32'h0);
		rd(8'h1c, 32'h0);
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			chan_in <= lfsr[7:0];
			settle(3);
			rd(`SDO_OFS_PINS, {24'h0, lfsr[7:0]});
		end
		cmd("$1RS\r", "*00020031\r");
		cmd("$1XY\r", "?1\r");
		default_n <= 1'b0;
		settle(12);
		`SDO_CHECK("dmode", 1'b1, default_mode)
		rd(`SDO_OFS_SETUP, `SDO_NV_RST);
		cmd("$ZRS\r", "*00020031\r");
		cmd("$ZSU0F021041\r", "*\r");
		rd(`SDO_OFS_STAT, 32'h00000140);
		rd(`SDO_OFS_SETUP, 32'h0f021041);
		wr(`SDO_OFS_CTRL, 32'h00000001);
		settle(2);
		`SDO_CHECK("cont", 1'b1, cont_mode)
		@(posedge clk);
		default_n <= 1'b1;
		settle(12);
		i_host.div = 8;
		`SDO_CHECK("cont", 1'b0, cont_mode)
		`SDO_CHECK("oe", 8'h0f, chan_oe)
		`SDO_CHECK("out", 8'h00, chan_out)
		rd(`SDO_OFS_STAT, 32'h00000101);
		cmd("$1RS\r", "");
		cmd("$ARS\r", "*0F021041\r");
		wr(`SDO_OFS_CTRL, 32'h00000003);
		settle(2);
		`SDO_CHECK("cont", 1'b0, cont_mode)
		// stored even parity only takes hold at the next program reset
		cmd("$ASU0F021841\r", "*\r");
		default_n <= 1'b0;
		settle(12);
		@(posedge clk);
		default_n <= 1'b1;
		settle(12);
		i_host.par = 2'h2;
		rd(`SDO_OFS_STAT, 32'h00000121);
		cmd("$ARS\r", "*0F021841\r");
		`SDO_CHECK("left", 0, exp_rx.size() + exp_rd.size())
		tally_and_finish();
	end
endmodule
`default_nettype wire
